// ===== qsfts_top.sv
// Queued serial transfer sequencer: FIFOs, sequencing and link hand-off
//
// Behaviour
// RL1: Power bit gates all operation and state.
// RL2: Software configures format before clearing pointers.
// RL3: Pointer clear resets all buffer pointers.
// RL4: Transmit-only enabled with mode in one write.
// RL5: Receive-only enabled with mode in one write.
// RL6: Full duplex sets both enables together.
// RL7: Software writes only while full flag low.
// RL8: Master writes chip select, then data.
// RL9: Slave leaves selects unused, data only.
// RL10: Dummy data write triggers receive-only element.
// RL11: Software sets item count before batch data.
// RL12: Transfer-end pulse marks batch completion.
// RL13: Receive reads pop elements in order.
// RL14: Single mode waits completion, reads, continues.
// RL15: Pointer clear and reload between batches.
// RL16: Clearing both enables ends duplex session.
// RL17: Receive-only keeps data-out level unchanged.
// RL18: Length field 1,0,0,0 selects eight bits.
// RL19: Write when sixteen queued: discard, overflow.
// RL20: Completion frees entry; full at sixteen.
// RL21: Selects inactive when disabled or unpowered.
`timescale 1ns/1ps
module qsfts_top #(
  parameter int DEPTH = qsfts_pkg::FIFO_DEPTH
) (
  input  wire logic                          I_CLOCK,
  input  wire logic                          I_RESET_N,
  input  wire logic                          I_LINK_CLOCK,
  input  wire logic                          I_POWER,
  input  wire logic                          I_TX_ENABLE,
  input  wire logic                          I_RX_ENABLE,
  input  wire logic                          I_MASTER,
  input  wire logic                          I_FIFO_MODE,
  input  wire logic [3:0]                    I_CHAR_LENGTH_FIELD,
  input  wire logic [3:0]                    I_ITEM_COUNT_FIELD,
  input  wire logic                          I_POINTER_CLEAR,
  input  wire logic                          I_CS_WR,
  input  wire logic [qsfts_pkg::CS_W-1:0]    I_CHIP_SELECT_DATA,
  input  wire logic                          I_TX_WR,
  input  wire logic [qsfts_pkg::DATA_W-1:0]  I_TX_DATA,
  input  wire logic                          I_RX_RD,
  input  wire logic                          I_SERIAL_DATA_IN,
  output logic                               O_TX_BUFFER_FULL_FLAG,
  output logic [qsfts_pkg::DATA_W-1:0]       O_RX_DATA,
  output logic                               O_RX_AVAILABLE,
  output logic                               O_TRANSFER_END_IRQ,
  output logic                               O_TX_OVERFLOW_IRQ,
  output logic                               O_SERIAL_CLOCK,
  output logic                               O_SERIAL_DATA_OUT,
  output logic [qsfts_pkg::CS_W-1:0]         O_CHIP_SELECT_OUT_N
);

  localparam int PW = $clog2(DEPTH);  // Index width; pointers carry one extra bit

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  qsfts_pkg::qsfts_elem_t         tx_mem_q [DEPTH];  // Queued elements
  logic [qsfts_pkg::DATA_W-1:0]   rx_mem_q [DEPTH];  // Received elements
  logic [PW:0]                    tx_wr_q;           // Transmit write pointer
  logic [PW:0]                    tx_ld_q;           // Shift-load pointer
  logic [PW:0]                    rx_wr_q;           // Receive write pointer
  logic [PW:0]                    rx_rd_q;           // Receive read pointer
  logic [qsfts_pkg::CS_W-1:0]     cs_hold_q;         // Select data waiting for its data word
  logic [qsfts_pkg::LEN_W-1:0]    batch_q;           // Elements done in this batch
  qsfts_pkg::qsfts_seq_t          state_q;           // Sequencer state
  qsfts_pkg::qsfts_req_t          req_q;             // Word held for the link
  logic                           req_tgl_q;         // Request event toggle
  logic                           en_q;              // Link enable level
  logic                           done_s1_q;         // First stage, read only by done_s2_q
  logic                           done_s2_q;         // Done toggle in core domain
  logic                           done_seen_q;       // Last done toggle handled
  logic [qsfts_pkg::DATA_W-1:0]   link_rx;           // Received word, stable at done
  logic                           link_done_tgl;     // Done toggle from link

  // Length field decode, 0 means sixteen
  function automatic logic [qsfts_pkg::LEN_W-1:0] len_of(input logic [3:0] f);
    len_of = (f == qsfts_pkg::CHAR_LEN_16) ? qsfts_pkg::LEN_MAX : {1'b0, f};  // RL18
  endfunction : len_of

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire              off       = !I_RESET_N || !I_POWER;                        // RL1
  wire              run       = I_POWER && (I_TX_ENABLE || I_RX_ENABLE);
  wire [PW:0]       tx_count  = tx_wr_q - tx_ld_q;
  wire [PW:0]       rx_count  = rx_wr_q - rx_rd_q;
  // Depth is a power of two, so a full queue is exactly the top count bit
  wire              tx_full   = tx_count[PW];                                  // RL20
  wire              rx_full   = rx_count[PW];
  wire              tx_push   = I_TX_WR && !tx_full;                          // RL8
  wire              overflow  = (I_CS_WR || I_TX_WR) && tx_full;              // RL19
  wire              done_evt  = (done_s2_q != done_seen_q) && (state_q == qsfts_pkg::SEQ_BUSY);
  wire              start     = (state_q == qsfts_pkg::SEQ_IDLE) && run && (tx_count != '0);
  wire [qsfts_pkg::LEN_W-1:0] items    = len_of(I_ITEM_COUNT_FIELD);
  wire [qsfts_pkg::LEN_W-1:0] batch_nx = batch_q + 5'h01;
  wire              batch_end = !I_FIFO_MODE || (batch_nx == items);          // RL12
  wire              rx_push   = done_evt && req_q.rx_en && !rx_full;
  wire              rx_pop    = I_RX_RD && (rx_count != '0);                  // RL13

  // ----------------------------------------------------------------
  // Queue memories (no reset needed on data)
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (tx_push) begin
      tx_mem_q[tx_wr_q[PW-1:0]] <= '{cs: I_MASTER ? cs_hold_q : '0, data: I_TX_DATA};  // RL9
    end
    if (rx_push) begin
      rx_mem_q[rx_wr_q[PW-1:0]] <= link_rx;
    end
  end

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  // Clear wins over a push or pop in the same cycle; pointers restart together
  always_ff @(posedge I_CLOCK) begin
    if (off || I_POINTER_CLEAR) begin                                          // RL3
      tx_wr_q <= '0;
      tx_ld_q <= '0;
      rx_wr_q <= '0;
      rx_rd_q <= '0;
      batch_q <= '0;
    end else begin
      if (tx_push)  tx_wr_q <= tx_wr_q + 1'b1;
      if (done_evt) tx_ld_q <= tx_ld_q + 1'b1;                                 // RL20
      if (rx_push)  rx_wr_q <= rx_wr_q + 1'b1;
      if (rx_pop)   rx_rd_q <= rx_rd_q + 1'b1;
      if (done_evt) batch_q <= batch_end ? '0 : batch_nx;
    end
  end

  // Select data stands until the data word that completes the element
  always_ff @(posedge I_CLOCK) begin
    if (off) begin
      cs_hold_q <= '0;
    end else if (I_CS_WR && !tx_full && I_MASTER) begin
      cs_hold_q <= I_CHIP_SELECT_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Any queued word starts a frame, so a dummy word starts a receive  RL10
  always_ff @(posedge I_CLOCK) begin
    if (off) begin
      state_q   <= qsfts_pkg::SEQ_IDLE;
      req_q     <= '0;
      req_tgl_q <= 1'b0;
    end else begin
      case (state_q)
        qsfts_pkg::SEQ_IDLE: begin
          if (start) begin                                                     // RL10
            req_q     <= '{master: I_MASTER, tx_en: I_TX_ENABLE, rx_en: I_RX_ENABLE,
                           len: len_of(I_CHAR_LENGTH_FIELD), elem: tx_mem_q[tx_ld_q[PW-1:0]]};
            req_tgl_q <= ~req_tgl_q;
            state_q   <= qsfts_pkg::SEQ_BUSY;
          end
        end
        qsfts_pkg::SEQ_BUSY: begin
          if (!run || I_POINTER_CLEAR || done_evt) begin
            state_q <= qsfts_pkg::SEQ_IDLE;  // Abort on disable leaves the element queued; pointer clear drops it
          end
        end
        default: begin
          state_q <= qsfts_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Done toggle crossing; tracks while idle so a late toggle is ignored
  always_ff @(posedge I_CLOCK) begin
    done_s1_q   <= link_done_tgl;
    done_s2_q   <= done_s1_q;
    done_seen_q <= off ? done_s2_q : done_s2_q;
    en_q        <= !off && run;                                                // RL21
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (off) begin
      O_TX_BUFFER_FULL_FLAG <= 1'b0;
      O_RX_DATA             <= qsfts_pkg::DATA_RESET;
      O_RX_AVAILABLE        <= 1'b0;
      O_TRANSFER_END_IRQ    <= 1'b0;
      O_TX_OVERFLOW_IRQ     <= 1'b0;
    end else begin
      O_TX_BUFFER_FULL_FLAG <= tx_full;                                        // RL20
      O_RX_DATA             <= rx_mem_q[rx_rd_q[PW-1:0]];                      // RL13
      O_RX_AVAILABLE        <= (rx_count != '0);
      O_TRANSFER_END_IRQ    <= done_evt && batch_end;                          // RL12
      O_TX_OVERFLOW_IRQ     <= overflow;                                       // RL19
    end
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  qsfts_link u_link (
    .i_link_clock (I_LINK_CLOCK),
    .i_enable     (en_q),
    .i_req_tgl    (req_tgl_q),
    .i_req        (req_q),
    .i_sdi        (I_SERIAL_DATA_IN),
    .o_done_tgl   (link_done_tgl),
    .o_rx_data    (link_rx),
    .o_sck        (O_SERIAL_CLOCK),
    .o_sdo        (O_SERIAL_DATA_OUT),
    .o_cs_n       (O_CHIP_SELECT_OUT_N)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);

  logic [5:0] slave_cnt_q;  // Cycles spent disabled, saturating
  always_ff @(posedge I_CLOCK) begin
    slave_cnt_q <= (!I_RESET_N || en_q) ? 6'h00 : ((slave_cnt_q == 6'h3f) ? slave_cnt_q : slave_cnt_q + 6'h01);
  end

  AST_POWER_OFF: assert property (!I_POWER |=> (tx_count == '0) && (state_q == qsfts_pkg::SEQ_IDLE))  // RL1
    else $error("State kept while unpowered");
  AST_PTR_CLEAR: assert property (I_POINTER_CLEAR |=> (tx_count == '0) && (rx_count == '0))  // RL3
    else $error("Pointer clear left entries");
  AST_OVERFLOW: assert property ((I_TX_WR && tx_full && I_POWER) |=> O_TX_OVERFLOW_IRQ && $stable(tx_wr_q))  // RL19
    else $error("Write into full queue not refused");
  AST_FULL_FLAG: assert property ((I_POWER && tx_count == DEPTH[PW:0]) |=> O_TX_BUFFER_FULL_FLAG)  // RL20
    else $error("Full flag missing at sixteen entries");
  AST_LOAD_ADV: assert property ((done_evt && !tx_push && I_POWER && !I_POINTER_CLEAR) |=>  // RL20
    tx_count == $past(tx_count) - 1'b1)
    else $error("Completion did not free an entry");
  AST_BATCH_END: assert property ((done_evt && I_FIFO_MODE && batch_nx == items && I_POWER) |=>  // RL12
    O_TRANSFER_END_IRQ)
    else $error("Batch end not signalled");
  AST_RX_POP: assert property ((rx_pop && !rx_push && I_POWER && !I_POINTER_CLEAR) |=>  // RL13
    rx_count == $past(rx_count) - 1'b1)
    else $error("Receive read did not advance");
  AST_TRIGGER: assert property ((start && I_POWER && !I_POINTER_CLEAR) |=>  // RL10
    (state_q == qsfts_pkg::SEQ_BUSY) && (req_tgl_q != $past(req_tgl_q)))
    else $error("Queued word did not start a frame");
  AST_CS_OFF: assert property ((slave_cnt_q == 6'h3f) |-> (O_CHIP_SELECT_OUT_N == qsfts_pkg::CS_IDLE_N))  // RL21
    else $error("Selects active while disabled");

endmodule : qsfts_top

// ===== qsfts_pkg.sv
// Shared constants, element layout and sequencer states for the queued serial sequencer
package qsfts_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          DATA_W      = 16;     // Widest element
  localparam int          CS_W        = 4;      // Chip-select lines
  localparam int          FIFO_DEPTH  = 16;     // Transmit and receive entries
  localparam int          LEN_W       = 5;      // Bit count 1..16
  localparam logic [3:0]  CHAR_LEN_8  = 4'h8;   // Field pattern 1,0,0,0
  localparam logic [3:0]  CHAR_LEN_16 = 4'h0;   // All-zero field means 16 bits
  localparam logic [4:0]  LEN_MAX     = 5'h10;  // Length for the all-zero field

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CS_W-1:0]   CS_IDLE_N   = 4'hf;     // All selects inactive (active low)
  localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000; // Cleared data words
  localparam logic              SDO_RESET   = 1'b0;     // Data out level after reset

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CS_W-1:0]   cs;    // Chip-select data of the element
    logic [DATA_W-1:0] data;  // Transmit data of the element
  } qsfts_elem_t;

  typedef struct packed {
    logic              master;  // Drive clock and selects
    logic              tx_en;   // Shift data out
    logic              rx_en;   // Keep received data
    logic [LEN_W-1:0]  len;     // Bits in the element
    qsfts_elem_t       elem;    // Payload
  } qsfts_req_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,  // Waiting for a queued element
    SEQ_BUSY = 2'b10   // Element handed to the link
  } qsfts_seq_t;

endpackage : qsfts_pkg

// ===== qsfts_link.sv
// Shift engine running on the serial link clock
`timescale 1ns/1ps
module qsfts_link (
  input  wire logic                          i_link_clock,
  input  wire logic                          i_enable,
  input  wire logic                          i_req_tgl,
  input  wire qsfts_pkg::qsfts_req_t         i_req,
  input  wire logic                          i_sdi,
  output logic                               o_done_tgl,
  output logic [qsfts_pkg::DATA_W-1:0]       o_rx_data,
  output logic                               o_sck,
  output logic                               o_sdo,
  output logic [qsfts_pkg::CS_W-1:0]         o_cs_n
);

  // ----------------------------------------------------------------
  // Crossing from the core clock
  // ----------------------------------------------------------------
  logic                          en_s1_q;    // First stage, read only by en_s2_q
  logic                          en_s2_q;    // Enable in link domain
  logic                          req_s1_q;   // First stage, read only by req_s2_q
  logic                          req_s2_q;   // Request toggle in link domain
  logic                          seen_q;     // Last request toggle served
  logic                          active_q;   // Element on the wire
  logic                          ph_q;       // Master half-period phase
  logic [qsfts_pkg::LEN_W-1:0]   cnt_q;      // Bits left
  logic [qsfts_pkg::DATA_W-1:0]  sh_q;       // Transmit shifter, MSB first
  logic [qsfts_pkg::DATA_W-1:0]  rx_q;       // Receive shifter
  qsfts_pkg::qsfts_req_t         cur_q;      // Element being shifted

  // Request word is stable whenever the toggle differs, so no word sync needed
  wire                           new_req  = (req_s2_q != seen_q) && !active_q;
  wire                           sample   = active_q && (!cur_q.master || !ph_q);
  wire                           step     = active_q && (!cur_q.master || ph_q);
  wire [qsfts_pkg::DATA_W-1:0]   rx_next  = sample ? {rx_q[qsfts_pkg::DATA_W-2:0], i_sdi} : rx_q;
  wire [qsfts_pkg::DATA_W-1:0]   sh_next  = {sh_q[qsfts_pkg::DATA_W-2:0], 1'b0};
  wire [qsfts_pkg::DATA_W-1:0]   sh_load  = i_req.elem.data <<
                                            (qsfts_pkg::LEN_MAX - i_req.len);

  // Two-flop level and toggle synchronisers
  always_ff @(posedge i_link_clock) begin
    en_s1_q  <= i_enable;
    en_s2_q  <= en_s1_q;
    req_s1_q <= i_req_tgl;
    req_s2_q <= req_s1_q;
  end

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  // Disable acts as the link-side reset, since this clock may stop between frames
  always_ff @(posedge i_link_clock) begin
    if (!en_s2_q) begin
      seen_q     <= req_s2_q;                  // Drop anything requested while off
      active_q   <= 1'b0;
      ph_q       <= 1'b0;
      cnt_q      <= '0;
      sh_q       <= qsfts_pkg::DATA_RESET;
      rx_q       <= qsfts_pkg::DATA_RESET;
      cur_q      <= '0;
      o_done_tgl <= 1'b0;
      o_rx_data  <= qsfts_pkg::DATA_RESET;
      o_sck      <= 1'b0;
      o_sdo      <= qsfts_pkg::SDO_RESET;
      o_cs_n     <= qsfts_pkg::CS_IDLE_N;      // RL21
    end else if (new_req) begin
      seen_q   <= req_s2_q;
      active_q <= 1'b1;
      ph_q     <= 1'b0;
      cnt_q    <= i_req.len;
      sh_q     <= sh_load;
      rx_q     <= qsfts_pkg::DATA_RESET;       // Fresh word keeps short elements right-aligned
      cur_q    <= i_req;
      o_cs_n   <= i_req.master ? ~i_req.elem.cs : qsfts_pkg::CS_IDLE_N;  // RL9
      if (i_req.tx_en) begin
        o_sdo <= sh_load[qsfts_pkg::DATA_W-1];  // Receive-only keeps level RL17
      end
    end else if (active_q) begin
      rx_q <= rx_next;
      if (cur_q.master) begin
        ph_q  <= ~ph_q;
        o_sck <= ~ph_q;                         // Rise on sample, fall on step
      end
      if (step) begin
        cnt_q <= cnt_q - 5'h01;
        sh_q  <= sh_next;
        if (cur_q.tx_en) begin
          o_sdo <= sh_next[qsfts_pkg::DATA_W-1];  // RL17
        end
        if (cnt_q == 5'h01) begin
          active_q   <= 1'b0;
          o_rx_data  <= rx_next;
          o_done_tgl <= ~o_done_tgl;            // Data stands before the toggle
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SDO_HOLD: assert property (@(posedge i_link_clock) disable iff (!en_s2_q)  // RL17
    (active_q && !cur_q.tx_en) |=> $stable(o_sdo))
    else $error("Data out moved during receive-only element");

  AST_CS_IDLE_OFF: assert property (@(posedge i_link_clock)  // RL21
    (!en_s2_q) |=> (o_cs_n == qsfts_pkg::CS_IDLE_N))
    else $error("Chip select active while link disabled");

endmodule : qsfts_link

// ===== qsfts_peer.sv
// Behavioural serial slave standing on the far side of the link
`timescale 1ns/1ps
module qsfts_peer (
  input  wire logic       i_sck,
  input  wire logic       i_sdo,
  input  wire logic [3:0] i_cs_n,
  output logic            o_sdi
);
  // ----------------------------------------------------------------
  // State seen by the bench
  // ----------------------------------------------------------------
  wire        sel       = ~&i_cs_n;   // Any line selected
  logic [7:0] reply     = 8'hc3;      // Next answer, rotates out MSB first
  logic [7:0] got       = 8'h00;      // Bits shifted in this frame
  logic [7:0] last_got  = 8'h00;      // Word of the finished frame
  logic [3:0] cs_seen   = 4'hf;       // Select pattern at frame start
  int         frames    = 0;          // Finished frames
  int         bits      = 0;          // Rising edges in this frame
  int         last_bits = 0;          // Rising edges of the finished frame
  time        fall_t    = 0;          // Last falling clock edge
  initial o_sdi = 1'b0;
  // Close one element and ready the next answer bit
  task automatic close_frame();
    frames++;
    last_got  = got;
    last_bits = bits;
    bits      = 0;
    reply     = reply + 8'h11;
    o_sdi     = reply[7];
  endtask : close_frame
  // Frame start: first answer bit must be ready before the first rise
  always @(posedge sel) begin
    bits  = 0;
    o_sdi = reply[7];
  end
  // Rise samples, fall shifts
  always @(posedge i_sck) if (sel) begin
    if (bits == 0) cs_seen = i_cs_n;
    got = {got[6:0], i_sdo};
    bits++;
  end
  always @(negedge i_sck) if (sel) begin
    fall_t = $time;
    reply  = {reply[6:0], reply[7]};
    o_sdi  = reply[7];
  end
  // Selects stay low between elements, so an element ends when the clock parks
  always #20 if (sel && bits > 0 && !i_sck && ($time - fall_t) > 240) close_frame();
  // Line released: it shows the inverse, never a stale bit
  always @(negedge sel) begin
    if (bits > 0) close_frame();
    o_sdi = ~o_sdi;
  end
endmodule : qsfts_peer

// ===== qsfts_top_bench.sv
// Self-checking bench: duplex, receive-only, batch, transmit-only, slave and overflow sequences
`timescale 1ns/1ps
module qsfts_top_bench;
  // ----------------------------------------------------------------
  // Stimulus and observed nets
  // ----------------------------------------------------------------
  logic        clk = 0, lclk = 0, rst_n = 0, pwr = 0, txe = 0, rxe = 0, fifo = 0;
  logic        pclr = 0, cswr = 0, txwr = 0, rxrd = 0, sdo_was = 0, mst = 1;
  logic [3:0]  clen = 4'h8, icnt = 4'h0, csd = 4'h0;
  logic [15:0] txd  = 16'h0000;
  wire         sdi, full, avail, tend, ovf, sck, sdo;
  wire  [3:0]  cs_n;
  wire  [15:0] rxd;
  int          fails = 0, cmp_count = 0, ends = 0, ovfs = 0;
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #80 lclk = ~lclk;
  end
  // Pulse counters, so a one-cycle pulse is never missed
  always @(posedge clk) begin
    if (tend === 1'b1) ends++;
    if (ovf === 1'b1) ovfs++;
  end
  qsfts_top uut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_LINK_CLOCK(lclk), .I_POWER(pwr),
    .I_TX_ENABLE(txe), .I_RX_ENABLE(rxe), .I_MASTER(mst), .I_FIFO_MODE(fifo),
    .I_CHAR_LENGTH_FIELD(clen), .I_ITEM_COUNT_FIELD(icnt), .I_POINTER_CLEAR(pclr),
    .I_CS_WR(cswr), .I_CHIP_SELECT_DATA(csd), .I_TX_WR(txwr), .I_TX_DATA(txd),
    .I_RX_RD(rxrd), .I_SERIAL_DATA_IN(sdi), .O_TX_BUFFER_FULL_FLAG(full), .O_RX_DATA(rxd),
    .O_RX_AVAILABLE(avail), .O_TRANSFER_END_IRQ(tend), .O_TX_OVERFLOW_IRQ(ovf),
    .O_SERIAL_CLOCK(sck), .O_SERIAL_DATA_OUT(sdo), .O_CHIP_SELECT_OUT_N(cs_n));
  qsfts_peer peer (.i_sck(sck), .i_sdo(sdo), .i_cs_n(cs_n), .o_sdi(sdi));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One select or data write; a pulse of exactly one cycle
  task automatic wr(input logic is_cs, input logic [15:0] v);
    @(posedge clk);
    if (is_cs) begin
      cswr <= 1'b1;
      csd  <= v[3:0];
    end else begin
      txwr <= 1'b1;
      txd  <= v;
    end
    @(posedge clk);
    cswr <= 1'b0;
    txwr <= 1'b0;
  endtask : wr
  task automatic clear_ptrs();
    @(posedge clk);
    pclr <= 1'b1;
    @(posedge clk);
    pclr <= 1'b0;
    tick(2);
  endtask : clear_ptrs
  // Head is shown before the pop; new head settles two cycles later
  task automatic rd(input logic [15:0] exp);
    chk(rxd, exp, "receive head");
    @(posedge clk);
    rxrd <= 1'b1;
    @(posedge clk);
    rxrd <= 1'b0;
    tick(3);
  endtask : rd
  // Bounded wait for the end count to reach a target
  task automatic wait_ends(input int target);
    int i;
    for (i = 0; i < 3000 && ends < target; i++) tick(1);
    if (ends < target) begin
      fails++;
      $display("wrong value at %0t: transfer end never came", $time);
      wrap_up();
    end
  endtask : wait_ends
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tick(8);
    chk({12'h000, cs_n}, 16'h000f, "selects while unpowered");
    @(posedge clk);
    pwr <= 1'b1;
    @(posedge clk);
    clen <= 4'h8;
    clear_ptrs();
    @(posedge clk);
    txe <= 1'b1;
    rxe <= 1'b1;
    wr(1'b1, 16'h0001);
    wr(1'b0, 16'h00a5);
    wait_ends(1);
    tick(8);
    chk({8'h00, peer.last_got}, 16'h00a5, "word shifted out");
    chk(16'(peer.last_bits), 16'h0008, "bits per element");
    chk({12'h000, peer.cs_seen}, 16'h000e, "select pattern");
    rd(16'h00c3);
    $display("test single duplex done");
    // Receive only: data out must hold, dummy write triggers the element
    @(posedge clk);
    txe <= 1'b0;
    tick(2);
    sdo_was = sdo;
    wr(1'b1, 16'h0001);
    wr(1'b0, 16'h005a);
    wait_ends(2);
    tick(8);
    chk({8'h00, peer.last_got}, {8'h00, {8{sdo_was}}}, "data out held");
    rd(16'h00d4);
    $display("test receive only done");
    // Batch of three: one end pulse for the whole batch
    @(posedge clk);
    fifo <= 1'b1;
    icnt <= 4'h3;
    txe  <= 1'b1;
    clear_ptrs();
    for (int k = 0; k < 3; k++) begin
      wr(1'b1, 16'h0002);
      wr(1'b0, 16'h0030 + 16'(k));
    end
    wait_ends(3);
    tick(10);
    chk(16'(ends), 16'h0003, "one end per batch");
    chk(16'(peer.frames), 16'h0005, "frames in batch");
    rd(16'h00e5);
    rd(16'h00f6);
    rd(16'h0007);
    chk({15'h0000, avail}, 16'h0000, "receive drained");
    $display("test batch done");
    // Transmit only: word goes out, nothing lands in the receive queue
    @(posedge clk);
    fifo <= 1'b0;
    rxe  <= 1'b0;
    tick(2);
    chk({15'h0000, full}, 16'h0000, "room before write");
    wr(1'b1, 16'h0001);
    wr(1'b0, 16'h003c);
    wait_ends(4);
    tick(8);
    chk({8'h00, peer.last_got}, 16'h003c, "transmit only word");
    chk({15'h0000, avail}, 16'h0000, "nothing received");
    $display("test transmit only done");
    // Slave: data write alone starts an element, selects stay idle
    @(posedge clk);
    mst <= 1'b0;
    tick(2);
    wr(1'b0, 16'h0055);
    wait_ends(5);
    tick(2);
    chk({12'h000, cs_n}, 16'h000f, "selects idle in slave");
    chk(16'(peer.frames), 16'h0006, "no frame in slave");
    $display("test slave done");
    // Overflow with the link idle
    @(posedge clk);
    txe <= 1'b0;
    rxe <= 1'b0;
    tick(14);
    chk({12'h000, cs_n}, 16'h000f, "selects when disabled");
    clear_ptrs();
    for (int k = 0; k < 16; k++) wr(1'b0, 16'(k));
    tick(3);
    chk({15'h0000, full}, 16'h0001, "full at sixteen");
    wr(1'b0, 16'h00ff);
    tick(3);
    chk(16'(ovfs), 16'h0001, "overflow pulse");
    chk(16'(peer.frames), 16'h0006, "no frame while disabled");
    clear_ptrs();
    chk({15'h0000, full}, 16'h0000, "full after clear");
    $display("test overflow done");
    @(posedge clk);
    pwr <= 1'b0;
    tick(10);
    chk({12'h000, cs_n}, 16'h000f, "selects when powered down");
    wrap_up();
  end
endmodule : qsfts_top_bench
